// ===== hdl/isw_pkg.sv
// Package for the byte-oriented two-wire slave with bus time-out.
// Assumes a plain register port with 8-bit data and 3-bit address.
package isw_pkg;

  // ----------------------------------------------------------------------
  // Register offsets.
  // ----------------------------------------------------------------------
  localparam logic [2:0] OFS_MODE    = 3'h0; // serial_mode_control_reg
  localparam logic [2:0] OFS_STATUS  = 3'h1; // bus_status_control_reg
  localparam logic [2:0] OFS_OWNADDR = 3'h2; // own_address_reg
  localparam logic [2:0] OFS_DATA    = 3'h3; // shift_data_reg
  localparam logic [2:0] OFS_TIMEOUT = 3'h4; // timeout_control_reg

  // ----------------------------------------------------------------------
  // Field positions.
  // ----------------------------------------------------------------------
  localparam int MODE_SEL_LSB = 5;  // serial_mode_select, bits 7:5.
  localparam int MODE_EN_BIT  = 1;  // serial_module_enable.
  localparam int ST_DONE_BIT  = 7;  // Byte transfer complete.
  localparam int ST_MATCH_BIT = 6;  // addr_match_flag.
  localparam int ST_BUSY_BIT  = 5;  // bus_busy_flag.
  localparam int ST_TXDIR_BIT = 4;  // transmit_direction.
  localparam int ST_ACKTX_BIT = 3;  // ack_to_send.
  localparam int ST_RDREQ_BIT = 2;  // master_read_request.
  localparam int ST_ACKRX_BIT = 0;  // ack_received_flag.
  localparam int TO_EN_BIT    = 7;  // timeout_enable.
  localparam int TO_FLAG_BIT  = 6;  // timeout_flag.
  localparam int OWN_LSB      = 1;  // Own address sits in bits 7:1.

  // ----------------------------------------------------------------------
  // Reset values and constants.
  // ----------------------------------------------------------------------
  localparam logic [7:0]  MODE_RESET    = 8'h00;
  localparam logic [7:0]  STATUS_RESET  = 8'h81;
  localparam logic [7:0]  OWN_RESET     = 8'h00;
  localparam logic [7:0]  TIMEOUT_RESET = 8'h00;
  localparam logic [2:0]  MODE_SLAVE    = 3'h6;
  localparam logic [10:0] TO_UNIT_TICKS = 11'h020; // 32 sub-clock periods.

  typedef enum logic [2:0] {
    ISW_IDLE     = 3'b000,
    ISW_ADDR     = 3'b001,
    ISW_ADDR_ACK = 3'b010,
    ISW_STRETCH  = 3'b011,
    ISW_RX_BITS  = 3'b100,
    ISW_RX_ACK   = 3'b101,
    ISW_TX_BITS  = 3'b110,
    ISW_TX_ACK   = 3'b111
  } isw_state_t;

endpackage : isw_pkg

// ===== hdl/isw_slave.sv
// Two-wire serial slave with address match, clock stretching and time-out.
// Assumes open-drain pins resolved outside and one-cycle register strobes.
//
// Notes on behaviour
// - After a sent byte, ninth-clock SDA low clears ack flag, high sets it.
// - As transmitter keep sending until ack flag is 1, then release SDA.
// - After START shift seven address bits MSB first, compare to own.
// - Address match sets match flag and pulses the serial interrupt.
// - Eighth bit after START is stored as master read request.
// - Read request 1 means slave transmits, 0 means slave receives.
// - START is SDA falling while SCL high; it sets bus busy.
// - Slave works only with mode select 110 and module enable 1.
// - Software-written own address is the address matched.
// - After match hold SCL low until data written or dummy read.
// - One interrupt from match, byte done and time-out.
// - Matching slave drives acknowledge after the address byte.
// - Transmit direction 1 selects slave transmit, 0 slave receive.
// - Data moves as MSB-first bytes via the data register after ack.
// - As receiver drive ack_to_send on SDA during the ninth clock.
// - Time-out counter starts on START plus match, clears on SCL fall.
// - Time-out when idle time exceeds period; STOP ends counting.
// - On time-out stop counter, clear enable, set flag, interrupt.
// - On time-out reset bus logic and status register only.
// - Period is (field plus one) times 32 sub-clock periods.
// - Time-out register: enable bit 7, flag bit 6, period bits 5..0.
`timescale 1ns/1ps
module isw_slave
  import isw_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       rstn,
  input  wire logic [2:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       scl_in,
  output logic            scl_out,
  output logic            scl_oe,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  input  wire logic       low_speed_clock,
  output logic            serial_irq
);

  // ----------------------------------------------------------------------
  // Pin synchronisers and edge detection.
  // ----------------------------------------------------------------------
  logic [1:0] scl_sync, sda_sync, lsc_sync;
  logic       scl_prev, sda_prev, lsc_prev;

  // Only the second stage of each chain feeds any logic.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      lsc_sync <= 2'h0;
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
      lsc_prev <= 1'b0;
    end else begin
      scl_sync <= {scl_sync[0], scl_in};
      sda_sync <= {sda_sync[0], sda_in};
      lsc_sync <= {lsc_sync[0], low_speed_clock};
      scl_prev <= scl_sync[1];
      sda_prev <= sda_sync[1];
      lsc_prev <= lsc_sync[1];
    end
  end

  logic scl_s, sda_s, scl_rise, scl_fall, start_det, stop_det, sub_tick;

  // Conditions need SCL high on both samples so an SCL edge is not misread.
  assign scl_s     = scl_sync[1];
  assign sda_s     = sda_sync[1];
  assign scl_rise  = scl_s & ~scl_prev;
  assign scl_fall  = ~scl_s & scl_prev;
  assign start_det = scl_s & scl_prev & sda_prev & ~sda_s;
  assign stop_det  = scl_s & scl_prev & ~sda_prev & sda_s;
  assign sub_tick  = lsc_sync[1] & ~lsc_prev;

  // ----------------------------------------------------------------------
  // Registers and control state.
  // ----------------------------------------------------------------------
  logic [7:0]  mode_reg, own_address_reg, shift_data_reg, shifter;
  logic [5:0]  timeout_period_select;
  logic [3:0]  bit_cnt;
  logic [11:0] to_count, to_limit;
  isw_state_t  state;
  logic        timeout_enable, timeout_flag, done_flag, addr_match_flag;
  logic        bus_busy_flag, transmit_direction, ack_to_send;
  logic        master_read_request, ack_received_flag, to_run, timeout_hit;
  logic        enabled, addr_ok, data_wr, data_rd;

  assign enabled = (mode_reg[MODE_SEL_LSB +: 3] == MODE_SLAVE)
                   & mode_reg[MODE_EN_BIT];
  assign addr_ok = shifter[7:1] == own_address_reg[OWN_LSB +: 7];
  assign data_wr = reg_wr & (reg_addr == OFS_DATA);
  assign data_rd = reg_rd & (reg_addr == OFS_DATA);
  // Limit is (field + 1) units of 32 ticks; 12 bits hold the 2048 maximum.
  assign to_limit = 12'({6'h00, timeout_period_select} + 12'h001)
                    * {1'b0, TO_UNIT_TICKS};
  assign timeout_hit = to_run & sub_tick & (to_count + 12'h001 >= to_limit)
                       & ~scl_fall;

  // Mode, own address and time-out period: plain software registers.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      mode_reg              <= MODE_RESET;
      own_address_reg       <= OWN_RESET;
      timeout_period_select <= TIMEOUT_RESET[5:0];
    end else if (reg_wr) begin
      if (reg_addr == OFS_MODE) begin
        mode_reg <= reg_wdata;
      end else if (reg_addr == OFS_OWNADDR) begin
        own_address_reg <= reg_wdata;
      end else if (reg_addr == OFS_TIMEOUT) begin
        timeout_period_select <= reg_wdata[5:0];
      end
    end
  end

  // Time-out enable and flag; a hardware set beats a software clear.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      timeout_enable <= TIMEOUT_RESET[TO_EN_BIT];
      timeout_flag   <= TIMEOUT_RESET[TO_FLAG_BIT];
    end else if (timeout_hit) begin
      timeout_enable <= 1'b0;
      timeout_flag   <= 1'b1;
    end else if (reg_wr && reg_addr == OFS_TIMEOUT) begin
      timeout_enable <= reg_wdata[TO_EN_BIT];
      timeout_flag   <= reg_wdata[TO_FLAG_BIT];
    end
  end

  // Time-out counter runs in sub-clock periods between SCL falls.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      to_run   <= 1'b0;
      to_count <= 12'h000;
    end else if (timeout_hit || stop_det || !enabled || !timeout_enable) begin
      to_run   <= 1'b0;
      to_count <= 12'h000;
    end else if (state == ISW_ADDR && scl_fall && bit_cnt == 4'h8
                 && addr_ok) begin
      to_run   <= 1'b1;
      to_count <= 12'h000;
    end else if (scl_fall) begin
      to_count <= 12'h000;
    end else if (to_run && sub_tick) begin
      to_count <= to_count + 12'h001;
    end
  end

  // ----------------------------------------------------------------------
  // Bus state machine, shifter and status flags.
  // ----------------------------------------------------------------------
  // Status returns to its reset image on time-out; data, address, mode stay.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state               <= ISW_IDLE;
      shifter             <= 8'h00;
      bit_cnt             <= 4'h0;
      shift_data_reg      <= 8'h00;
      done_flag           <= STATUS_RESET[ST_DONE_BIT];
      addr_match_flag     <= STATUS_RESET[ST_MATCH_BIT];
      bus_busy_flag       <= STATUS_RESET[ST_BUSY_BIT];
      transmit_direction  <= STATUS_RESET[ST_TXDIR_BIT];
      ack_to_send         <= STATUS_RESET[ST_ACKTX_BIT];
      master_read_request <= STATUS_RESET[ST_RDREQ_BIT];
      ack_received_flag   <= STATUS_RESET[ST_ACKRX_BIT];
      serial_irq          <= 1'b0;
    end else if (timeout_hit || !enabled) begin
      state               <= ISW_IDLE;
      bit_cnt             <= 4'h0;
      done_flag           <= STATUS_RESET[ST_DONE_BIT];
      addr_match_flag     <= STATUS_RESET[ST_MATCH_BIT];
      bus_busy_flag       <= STATUS_RESET[ST_BUSY_BIT];
      transmit_direction  <= STATUS_RESET[ST_TXDIR_BIT];
      ack_to_send         <= STATUS_RESET[ST_ACKTX_BIT];
      master_read_request <= STATUS_RESET[ST_RDREQ_BIT];
      ack_received_flag   <= STATUS_RESET[ST_ACKRX_BIT];
      serial_irq          <= timeout_hit;
      if (data_wr) begin
        shift_data_reg <= reg_wdata;
      end
    end else begin
      serial_irq <= 1'b0;
      if (reg_wr && reg_addr == OFS_STATUS) begin
        transmit_direction <= reg_wdata[ST_TXDIR_BIT];
        ack_to_send        <= reg_wdata[ST_ACKTX_BIT];
      end
      if (data_wr) begin
        shift_data_reg <= reg_wdata;
      end
      if (start_det) begin
        // A repeated START also restarts the address phase.
        state           <= ISW_ADDR;
        bit_cnt         <= 4'h0;
        bus_busy_flag   <= 1'b1;
        addr_match_flag <= 1'b0;
      end else if (stop_det) begin
        state         <= ISW_IDLE;
        bus_busy_flag <= 1'b0;
      end else begin
        case (state)
          ISW_ADDR: begin
            if (scl_rise) begin
              shifter <= {shifter[6:0], sda_s};
              bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall && bit_cnt == 4'h8) begin
              bit_cnt <= 4'h0;
              if (addr_ok) begin
                state               <= ISW_ADDR_ACK;
                addr_match_flag     <= 1'b1;
                master_read_request <= shifter[0];
                serial_irq          <= 1'b1;
              end else begin
                state <= ISW_IDLE;
              end
            end
          end
          ISW_ADDR_ACK: begin
            if (scl_fall) begin
              state <= ISW_STRETCH;
            end
          end
          ISW_STRETCH: begin
            // Direction follows the software bit; a mismatch is user error.
            if (transmit_direction && data_wr) begin
              state     <= ISW_TX_BITS;
              shifter   <= reg_wdata;
              bit_cnt   <= 4'h0;
              done_flag <= 1'b0;
            end else if (!transmit_direction && data_rd) begin
              state     <= ISW_RX_BITS;
              bit_cnt   <= 4'h0;
              done_flag <= 1'b0;
            end
          end
          ISW_RX_BITS: begin
            if (scl_rise) begin
              shifter <= {shifter[6:0], sda_s};
              bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall && bit_cnt == 4'h8) begin
              state           <= ISW_RX_ACK;
              shift_data_reg  <= shifter;
              done_flag       <= 1'b1;
              addr_match_flag <= 1'b0;
              serial_irq      <= 1'b1;
            end
          end
          ISW_RX_ACK: begin
            if (scl_fall) begin
              state <= ISW_STRETCH;
            end
          end
          ISW_TX_BITS: begin
            if (scl_fall) begin
              shifter <= {shifter[6:0], 1'b0};
              bit_cnt <= bit_cnt + 4'h1;
              if (bit_cnt == 4'h7) begin
                state <= ISW_TX_ACK;
              end
            end
          end
          ISW_TX_ACK: begin
            if (scl_rise) begin
              ack_received_flag <= sda_s;
            end else if (scl_fall) begin
              done_flag       <= 1'b1;
              addr_match_flag <= 1'b0;
              serial_irq      <= 1'b1;
              // No acknowledge: leave SDA free and wait for STOP.
              state <= ack_received_flag ? ISW_IDLE
                                         : ISW_STRETCH;
            end
          end
          default: begin
            state <= ISW_IDLE;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // Open-drain pin drive; outputs only ever pull low.
  // ----------------------------------------------------------------------
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe  = (state == ISW_STRETCH);
  always_comb begin
    case (state)
      ISW_ADDR_ACK: sda_oe = 1'b1;
      ISW_RX_ACK:   sda_oe = ~ack_to_send;
      ISW_TX_BITS:  sda_oe = ~shifter[7];
      default:      sda_oe = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------------
  // Register read port; unmapped offsets read zero.
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= 8'h00;
    end else if (!reg_rd) begin
      reg_rdata <= 8'h00;
    end else if (reg_addr == OFS_MODE) begin
      reg_rdata <= mode_reg;
    end else if (reg_addr == OFS_STATUS) begin
      reg_rdata <= {done_flag, addr_match_flag, bus_busy_flag,
                    transmit_direction, ack_to_send, master_read_request,
                    1'b0, ack_received_flag};
    end else if (reg_addr == OFS_OWNADDR) begin
      reg_rdata <= own_address_reg;
    end else if (reg_addr == OFS_DATA) begin
      reg_rdata <= shift_data_reg;
    end else if (reg_addr == OFS_TIMEOUT) begin
      reg_rdata <= {timeout_enable, timeout_flag, timeout_period_select};
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // ----------------------------------------------------------------------
  // Assertions and cover points.
  // ----------------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  property p_start_busy;
    enabled && start_det && !timeout_hit |=> bus_busy_flag;
  endproperty
  a_start_busy: assert property (p_start_busy)
    else $error("START did not set bus busy");
  property p_match_irq;
    $rose(addr_match_flag) |-> serial_irq && state == ISW_ADDR_ACK;
  endproperty
  a_match_irq: assert property (p_match_irq)
    else $error("Address match without interrupt");
  property p_addr_ack;
    state == ISW_ADDR_ACK |-> sda_oe && !scl_oe;
  endproperty
  a_addr_ack: assert property (p_addr_ack)
    else $error("Address acknowledge not driven");
  property p_stretch;
    state == ISW_STRETCH && !data_wr && !data_rd && !start_det
      && !stop_det && !timeout_hit && enabled |=> scl_oe;
  endproperty
  a_stretch: assert property (p_stretch)
    else $error("SCL released without service");
  property p_disabled_idle;
    !enabled |=> state == ISW_IDLE && !scl_oe;
  endproperty
  a_disabled_idle: assert property (p_disabled_idle)
    else $error("Slave active while disabled");
  property p_timeout_effect;
    timeout_hit |=> timeout_flag && !timeout_enable && serial_irq
      && !to_run && state == ISW_IDLE;
  endproperty
  a_timeout_effect: assert property (p_timeout_effect)
    else $error("Time-out effects missing");
  property p_timeout_status;
    timeout_hit && !reg_wr |=> !bus_busy_flag && !addr_match_flag && done_flag
      && ack_received_flag && !transmit_direction && !ack_to_send
      && !master_read_request && $stable(own_address_reg)
      && $stable(mode_reg) && $stable(shift_data_reg);
  endproperty
  a_timeout_status: assert property (p_timeout_status)
    else $error("Status not reset on time-out");
  property p_rx_ack;
    state == ISW_RX_ACK |-> sda_oe == !ack_to_send;
  endproperty
  a_rx_ack: assert property (p_rx_ack)
    else $error("Receiver acknowledge level wrong");
  property p_stop_ends;
    stop_det |=> !to_run [*2];
  endproperty
  a_stop_ends: assert property (p_stop_ends)
    else $error("Time-out still running after STOP");
  property p_rdreq;
    state == ISW_ADDR && scl_fall && bit_cnt == 4'h8 && addr_ok
      && enabled && !start_det && !stop_det && !timeout_hit
      |=> master_read_request == $past(shifter[0]);
  endproperty
  a_rdreq: assert property (p_rdreq)
    else $error("Read request bit not captured");
  c_match:   cover property ($rose(addr_match_flag));
  c_rx_byte: cover property (state == ISW_RX_ACK);
  c_tx_nack: cover property (state == ISW_TX_ACK ##1 state == ISW_IDLE);
  c_timeout: cover property (timeout_hit);

endmodule : isw_slave

// ===== verif/isw_master.sv
// Bit-banged bus master that faces the two-wire slave in the bench.
// Assumes pull-ups on SCL and SDA; the bench resolves the wire levels.
`timescale 1ns/1ps
module isw_master (
  input  wire logic clk,
  input  wire logic scl,
  input  wire logic sda,
  output logic      scl_lo,
  output logic      sda_lo
);
  // Both wires start released, so the bus idles high.
  initial begin
    scl_lo = 1'b0;
    sda_lo = 1'b0;
  end

  // Eight core cycles, 80 ns; a bit takes three of these plus the wait for SCL high.
  task automatic hc();
    repeat (8) @(posedge clk);
  endtask : hc

  // The slave may stretch, so the wait for SCL high is bounded.
  task automatic go_hi();
    int n;
    n = 0;
    scl_lo <= 1'b0;
    while (scl !== 1'b1 && n < 4000) begin
      @(posedge clk);
      n++;
    end
    hc();
  endtask : go_hi

  // One clock pulse; the wire level is taken late in the high phase.
  task automatic sbit(input logic b, output logic r);
    sda_lo <= ~b;
    hc();
    go_hi();
    r = sda;
    scl_lo <= 1'b1;
    hc();
  endtask : sbit

  // Eight bits, most significant first; send 8'hFF to read a byte.
  task automatic sbyte(input logic [7:0] d, output logic [7:0] r);
    for (int i = 7; i >= 0; i--) sbit(d[i], r[i]);
  endtask : sbyte

  // SDA falls while SCL is high.
  task automatic start();
    sda_lo <= 1'b0;
    go_hi();
    sda_lo <= 1'b1;
    hc();
    scl_lo <= 1'b1;
    hc();
  endtask : start

  // SDA rises while SCL is high; SCL is left released.
  task automatic stop();
    sda_lo <= 1'b1;
    hc();
    go_hi();
    sda_lo <= 1'b0;
    hc();
  endtask : stop
endmodule : isw_master

// ===== verif/tb_top.sv
// Self-checking bench for the two-wire slave with bus time-out.
// Assumes the master model in isw_master.sv and pull-ups on both wires.
`timescale 1ns/1ps
module tb_top;
  import isw_pkg::*;
  logic        core_clk = 1'b0;
  logic        rstn = 1'b0;
  logic        low_speed_clock = 1'b0;
  logic [2:0]  reg_addr = 3'h0;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [7:0]  reg_rdata, v, d;
  logic        scl_out, scl_oe, sda_out, sda_oe, serial_irq;
  logic        scl_lo, sda_lo, r;
  wire         scl = ~(scl_lo | scl_oe);
  wire         sda = ~(sda_lo | sda_oe);
  logic [31:0] seed = 32'h0000_1310;
  logic [6:0]  own;
  int          n_fail = 0, comparisons = 0, n_irq = 0, cyc = 0, n0, w;

  always #5 core_clk = ~core_clk;
  always #50 low_speed_clock = ~low_speed_clock;

  isw_slave dut (.core_clk(core_clk), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .scl_in(scl), .scl_out(scl_out),
    .scl_oe(scl_oe), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .low_speed_clock(low_speed_clock), .serial_irq(serial_irq));
  isw_master m (.clk(core_clk), .scl(scl), .sda(sda), .scl_lo(scl_lo),
    .sda_lo(sda_lo));

  // Interrupt pulses are counted; a hang is cut short by the cycle count.
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (serial_irq === 1'b1)
      n_irq <= n_irq + 1;
    if (cyc == 20000) begin
      n_fail++;
      wrap_up();
    end
  end

  // --------------------------------------------------------------------
  // Helpers.
  // --------------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic chk(input string nm, input logic [7:0] e, g);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wr(input logic [2:0] a, input logic [7:0] x);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= x;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe, so look mid-cycle.
  task automatic rchk(input logic [2:0] a, input logic [7:0] e, k);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd   <= 1'b0;
    @(negedge core_clk);
    v = reg_rdata;
    chk($sformatf("reg%0d", a), e & k, v & k);
  endtask : rchk

  // START, calling address and direction; r returns the address ack.
  task automatic call(input logic [6:0] a, input logic rw);
    m.start();
    m.sbyte({a, rw}, v);
    m.sbit(1'b1, r);
  endtask : call

  task automatic wrap_up();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : wrap_up

  // --------------------------------------------------------------------
  // Main sequence.
  // --------------------------------------------------------------------
  initial begin
    repeat (16) @(posedge core_clk);
    rstn <= 1'b1;
    rchk(OFS_STATUS, STATUS_RESET, 8'hFF);
    rchk(OFS_TIMEOUT, TIMEOUT_RESET, 8'hFF);
    rchk(3'h5, 8'h00, 8'hFF);
    seed = lfsr(seed);
    own = seed[6:0];
    wr(OFS_OWNADDR, {own, 1'b0});
    call(own, 1'b0);
    chk("ack_off", 8'h01, {7'h0, r});
    m.stop();
    $display("test reset and disabled done");
    // Receive two random bytes, the second one refused.
    wr(OFS_MODE, {MODE_SLAVE, 5'h02});
    n0 = n_irq;
    call(own, 1'b0);
    chk("ack_addr", 8'h00, {7'h0, r});
    chk("irq", 8'(n0 + 1), 8'(n_irq));
    rchk(OFS_STATUS, 8'h60, 8'h7C);
    chk("stretch", 8'h01, {7'h0, scl_oe});
    rchk(OFS_DATA, 8'h00, 8'hFF);
    for (int i = 0; i < 2; i++) begin
      seed = lfsr(seed);
      d = seed[7:0];
      m.sbyte(d, v);
      m.sbit(1'b1, r);
      chk("ack_rx", {7'h0, i[0]}, {7'h0, r});
      chk("stretch", 8'h01, {7'h0, scl_oe});
      rchk(OFS_DATA, d, 8'hFF);
      wr(OFS_STATUS, 8'h08);
    end
    chk("irq", 8'(n0 + 3), 8'(n_irq));
    m.stop();
    rchk(OFS_STATUS, 8'h00, 8'h20);
    $display("test receive done");
    // Transmit two random bytes; the master refuses the second.
    call(own, 1'b1);
    rchk(OFS_STATUS, 8'h64, 8'h64);
    wr(OFS_STATUS, 8'h10);
    for (int i = 0; i < 2; i++) begin
      seed = lfsr(seed);
      wr(OFS_DATA, seed[7:0]);
      m.sbyte(8'hFF, v);
      chk("tx", seed[7:0], v);
      m.sbit(i[0], r);
      rchk(OFS_STATUS, {7'h0, i[0]}, 8'h01);
    end
    chk("sda_free", 8'h00, {7'h0, sda_oe});
    m.stop();
    $display("test transmit done");
    // Foreign address: no ack, the master ends with STOP.
    call(own ^ 7'h01, 1'b0);
    chk("ack_other", 8'h01, {7'h0, r});
    m.stop();
    $display("test foreign address done");
    // Time-out with the shortest period while the slave stretches.
    wr(OFS_TIMEOUT, 8'h80);
    n0 = n_irq;
    call(own, 1'b0);
    for (w = 0; w < 1000 && n_irq < n0 + 2; w++) @(posedge core_clk);
    chk("to_time", 8'h01, {7'h0, w > 290 && w < 345});
    rchk(OFS_TIMEOUT, 8'h40, 8'hFF);
    rchk(OFS_STATUS, STATUS_RESET, 8'hFF);
    rchk(OFS_OWNADDR, {own, 1'b0}, 8'hFE);
    rchk(OFS_MODE, {MODE_SLAVE, 5'h02}, 8'hFF);
    chk("pins_low", 8'h00, {6'h0, scl_out, sda_out});
    chk("scl_free", 8'h00, {7'h0, scl_oe});
    m.stop();
    $display("test time-out done");
    // STOP well before the limit: counting ends and no time-out follows.
    wr(OFS_TIMEOUT, 8'h80);
    rchk(OFS_TIMEOUT, 8'h80, 8'hFF);
    n0 = n_irq;
    call(own, 1'b0);
    rchk(OFS_DATA, seed[7:0], 8'hFF);
    m.stop();
    repeat (400) @(posedge core_clk);
    chk("irq", 8'(n0 + 1), 8'(n_irq));
    rchk(OFS_TIMEOUT, 8'h80, 8'hFF);
    $display("test stop before time-out done");
    wrap_up();
  end
endmodule : tb_top
